//--- pointer_mover_defs.vh
// Purpose: constants for the receive pointer mover
// Assumes: one STS-1 frame of 9 rows by 90 columns per system frame
// Notes: word registers on classic Wishbone, byte address = offset
`ifndef POINTER_MOVER_DEFS_VH
`define POINTER_MOVER_DEFS_VH
`define ST_NORMAL 2'h0
`define ST_AIS 2'h1
`define ST_CHAIN 2'h2
`define PK_NORMAL 2'h0
`define PK_CHAIN 2'h1
`define PK_AIS 2'h2
`define PK_INVALID 2'h3
`define PTR_MAX 10'h30e
`define COL_LAST 7'h59
`define ROW_LAST 4'h8
`define ROW_H 4'h3
`define ROW_F1 4'h1
`define ROW_E2 4'h8
`define COL_F1E2 7'h02
`define COL_TOH_END 7'h02
`define COL_H1 7'h00
`define COL_H2 7'h01
`define INC_MASK 10'h2aa
`define DEC_MASK 10'h155
`define NDF_ON 4'h9
`define NDF_OFF 4'h6
`define ALL_ONES 8'hff
`define ADR_CTRL 5'h00
`define ADR_CHAN_EN 5'h04
`define ADR_PROT 5'h08
`define ADR_LINK_SEL 5'h0c
`define ADR_STATUS 5'h10
`define CTRL_PM_BYP 0
`define CTRL_FIFO_BYP 1
`define CTRL_8B10B 2
`define CTRL_STS12 3
`define CTRL_STS48 4
`define CTRL_BY_MACRO 5
`define CTRL_LINK_SW 6
`define CTRL_RST 7'h00
`define CHAN_RST 8'h00
`endif

//--- sts_receive_pointer_mover.v
// Purpose: receive pointer interpreter, generator, bypass and protection steering
// Assumes: upstream framer supplies per-frame pointer decisions on clk_i
// Notes: per-channel recovered timing is flagged, not clocked, here
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`include "pointer_mover_defs.vh"
module sts_receive_pointer_mover (
  input wire clk_i,
  input wire rst_i,
  input wire [4:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire we_i,
  input wire cyc_i,
  input wire stb_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire ptr_strobe_i,
  input wire [1:0] ptr_kind_i,
  input wire [9:0] ptr_value_i,
  input wire ptr_inc_i,
  input wire ptr_dec_i,
  input wire rx_h_time_i,
  input wire line_frame_pulse_i,
  input wire [7:0] es_data_i,
  input wire es_path_start_marker_i,
  input wire [7:0] fifo_data_i,
  input wire fifo_frame_pulse_i,
  input wire fifo_comma_i,
  input wire [7:0] framer_data_i,
  input wire framer_frame_pulse_i,
  input wire decoder_comma_i,
  input wire [1:0] protect_switch_pin_i,
  input wire [7:0] link_protect_select_i,
  output reg [7:0] out_data_o,
  output reg out_spe_o,
  output reg path_start_marker_o,
  output reg out_parity_o,
  output reg aligned_frame_pulse_o,
  output reg comma_detect_flag_o,
  output reg recovered_timing_o,
  output reg new_data_flag_o,
  output reg ptr_inc_o,
  output reg ptr_dec_o,
  output reg [7:0] powerdown_o,
  output reg [7:0] serial_interface_macro_pd_o,
  output reg [1:0] par_protect_o,
  output reg [1:0] ser_protect_o,
  output reg macro_protect_o,
  output reg [7:0] link_rx_sel_o
);
  reg [6:0] ctrl_reg;
  reg [7:0] chan_en_reg;
  reg [4:0] prot_reg;
  reg [7:0] link_sw_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [9:0] offset_reg;
  reg [9:0] offset_next;
  reg [1:0] last_kind_reg;
  reg last_diff_reg;
  reg have_one_reg;
  reg inc_pend_reg;
  reg dec_pend_reg;
  reg [6:0] col_reg;
  reg [3:0] row_reg;
  reg [9:0] pay_idx_reg;
  reg [9:0] gen_offset_reg;
  reg ais_fill_reg;
  reg ndf_reg;
  reg latch_e2_reg;
  reg phase_set_reg;
  reg [1:0] pin_meta_reg;
  reg [1:0] pin_sync_reg;
  wire req = cyc_i & stb_i & ~ack_o;
  wire pm_byp = ctrl_reg[`CTRL_PM_BYP];
  wire fifo_byp = ctrl_reg[`CTRL_FIFO_BYP];
  wire mode_8b = ctrl_reg[`CTRL_8B10B];
  wire full_byp = pm_byp & fifo_byp;
  wire prot_ok = ~mode_8b & ~full_byp;
  wire pair = ptr_strobe_i & have_one_reg & (ptr_kind_i == last_kind_reg);
  wire nc_now = (ptr_kind_i == `PK_NORMAL) | (ptr_kind_i == `PK_CHAIN);
  wire nc_last = (last_kind_reg == `PK_NORMAL) | (last_kind_reg == `PK_CHAIN);
  wire nc_pair = ptr_strobe_i & have_one_reg & nc_now & nc_last;
  wire diff_now = ptr_value_i != offset_reg;
  // adopted pointer must not count towards the next pair
  wire adopt = pair & (ptr_kind_i == `PK_NORMAL) & diff_now & last_diff_reg & (ptr_value_i <= `PTR_MAX);
  wire toh = col_reg <= `COL_TOH_END;
  wire h_time = (row_reg == `ROW_H) & toh;
  wire f1_time = (row_reg == `ROW_F1) & (col_reg == `COL_F1E2);
  wire e2_time = (row_reg == `ROW_E2) & (col_reg == `COL_F1E2);
  wire latch_now = latch_e2_reg ? e2_time : f1_time;
  wire [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [31:0] status = {16'h0000, offset_reg, 1'b0, phase_set_reg, latch_e2_reg, ais_fill_reg, state_reg};
  wire [9:0] out_ptr = gen_offset_reg ^ (ptr_inc_o ? `INC_MASK : 10'h000) ^
    (ptr_dec_o ? `DEC_MASK : 10'h000);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction
  wire [31:0] ctrl_m = merge({25'h0, ctrl_reg}, dat_i, wmask);
  wire [31:0] chan_m = merge({24'h0, chan_en_reg}, dat_i, wmask);
  wire [31:0] prot_m = merge({27'h0, prot_reg}, dat_i, wmask);
  wire [31:0] link_m = merge({24'h0, link_sw_reg}, dat_i, wmask);

  // wishbone slave, one wait state, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      ctrl_reg <= `CTRL_RST;
      chan_en_reg <= `CHAN_RST;
      prot_reg <= 5'h00;
      link_sw_reg <= 8'h00;
    end else begin
      ack_o <= req;
      if (req & we_i) begin
        case (adr_i)
          `ADR_CTRL: ctrl_reg <= ctrl_m[6:0];
          `ADR_CHAN_EN: chan_en_reg <= chan_m[7:0];
          `ADR_PROT: prot_reg <= prot_m[4:0];
          `ADR_LINK_SEL: link_sw_reg <= link_m[7:0];
          default: ;
        endcase
      end
      if (req & ~we_i) begin
        case (adr_i)
          `ADR_CTRL: dat_o <= {25'h0, ctrl_reg};
          `ADR_CHAN_EN: dat_o <= {24'h0, chan_en_reg};
          `ADR_PROT: dat_o <= {27'h0, prot_reg};
          `ADR_LINK_SEL: dat_o <= {24'h0, link_sw_reg};
          `ADR_STATUS: dat_o <= status;
          default: dat_o <= 32'h00000000;
        endcase
      end else begin
        dat_o <= 32'h00000000;
      end
    end
  end

  // interpreter next state; decisions arrive already majority-voted
  always @* begin
    state_next = state_reg;
    offset_next = offset_reg;
    case (state_reg)
      `ST_AIS: begin
        if (nc_pair) begin
          state_next = (ptr_kind_i == `PK_CHAIN) ? `ST_CHAIN : `ST_NORMAL;
        end
      end
      `ST_NORMAL, `ST_CHAIN: begin
        if (pair & (ptr_kind_i == `PK_AIS)) begin
          state_next = `ST_AIS;
        end else if (pair & (ptr_kind_i == `PK_CHAIN)) begin
          state_next = `ST_CHAIN;
        end else if (pair & (ptr_kind_i == `PK_NORMAL)) begin
          state_next = `ST_NORMAL;
        end
      end
      default: state_next = `ST_NORMAL;
    endcase
    // lone differing pointer leaves offset alone
    if (adopt) begin
      offset_next = ptr_value_i;
    end else if (ptr_strobe_i & ptr_inc_i & (state_reg != `ST_AIS)) begin
      offset_next = (offset_reg == `PTR_MAX) ? 10'h000 : offset_reg + 10'h001;
    end else if (ptr_strobe_i & ptr_dec_i & (state_reg != `ST_AIS)) begin
      offset_next = (offset_reg == 10'h000) ? `PTR_MAX : offset_reg - 10'h001;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= `ST_NORMAL;
      offset_reg <= 10'h000;
      last_kind_reg <= `PK_INVALID;
      last_diff_reg <= 1'b0;
      have_one_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      offset_reg <= offset_next;
      if (ptr_strobe_i) begin
        // invalid or changed kind restarts the run, except that normal and chain still pair in AIS
        last_kind_reg <= ptr_kind_i;
        have_one_reg <= (ptr_kind_i != `PK_INVALID);
        last_diff_reg <= diff_now & (ptr_kind_i == `PK_NORMAL) & (ptr_value_i <= `PTR_MAX) & ~adopt;
      end
    end
  end

  // system frame position from fabric frame pulse
  always @(posedge clk_i) begin
    if (rst_i) begin
      col_reg <= 7'h00;
      row_reg <= 4'h0;
      pay_idx_reg <= 10'h000;
    end else begin
      if (line_frame_pulse_i) begin
        col_reg <= 7'h00;
        row_reg <= 4'h0;
      end else if (col_reg == `COL_LAST) begin
        col_reg <= 7'h00;
        row_reg <= (row_reg == `ROW_LAST) ? 4'h0 : row_reg + 4'h1;
      end else begin
        col_reg <= col_reg + 7'h01;
      end
      if (h_time & (col_reg == `COL_TOH_END)) begin
        pay_idx_reg <= 10'h000;
      end else if (~toh) begin
        pay_idx_reg <= (pay_idx_reg == `PTR_MAX) ? 10'h000 : pay_idx_reg + 10'h001;
      end
    end
  end

  // adjustment latch point selection
  always @(posedge clk_i) begin
    if (rst_i) begin
      latch_e2_reg <= 1'b0;
      phase_set_reg <= 1'b0;
      inc_pend_reg <= 1'b0;
      dec_pend_reg <= 1'b0;
      ptr_inc_o <= 1'b0;
      ptr_dec_o <= 1'b0;
    end else begin
      if (rx_h_time_i & ~phase_set_reg) begin
        phase_set_reg <= 1'b1;
        latch_e2_reg <= f1_time;
      end else if (rx_h_time_i & latch_now) begin
        latch_e2_reg <= ~latch_e2_reg;
      end
      if (latch_now) begin
        inc_pend_reg <= 1'b0;
        dec_pend_reg <= 1'b0;
        ptr_inc_o <= inc_pend_reg | (ptr_strobe_i & ptr_inc_i);
        ptr_dec_o <= dec_pend_reg | (ptr_strobe_i & ptr_dec_i);
      end else if (ptr_strobe_i) begin
        inc_pend_reg <= inc_pend_reg | ptr_inc_i;
        dec_pend_reg <= dec_pend_reg | ptr_dec_i;
      end
    end
  end

  // generator offset tracking, fill and new data
  always @(posedge clk_i) begin
    if (rst_i) begin
      gen_offset_reg <= 10'h000;
      ais_fill_reg <= 1'b0;
      ndf_reg <= 1'b0;
    end else begin
      if (state_next == `ST_AIS) begin
        ais_fill_reg <= 1'b1;
      end else if (es_path_start_marker_i) begin
        ais_fill_reg <= 1'b0;
      end
      if (es_path_start_marker_i & (pay_idx_reg != gen_offset_reg)) begin
        gen_offset_reg <= pay_idx_reg;
        ndf_reg <= 1'b1;
      end else if ((state_reg == `ST_AIS) & (state_next != `ST_AIS)) begin
        ndf_reg <= 1'b1;
      end else if (row_reg == `ROW_H & col_reg == `COL_TOH_END) begin
        ndf_reg <= 1'b0;
      end
    end
  end

  // output data path and bypass steering
  always @(posedge clk_i) begin
    if (rst_i) begin
      out_data_o <= 8'h00;
      out_spe_o <= 1'b0;
      path_start_marker_o <= 1'b0;
      out_parity_o <= 1'b0;
      aligned_frame_pulse_o <= 1'b0;
      comma_detect_flag_o <= 1'b0;
      recovered_timing_o <= 1'b0;
      new_data_flag_o <= 1'b0;
    end else begin
      new_data_flag_o <= ndf_reg;
      comma_detect_flag_o <= fifo_byp ? decoder_comma_i : fifo_comma_i;
      recovered_timing_o <= fifo_byp & (pm_byp | mode_8b);
      if (full_byp & ~mode_8b) begin
        out_data_o <= framer_data_i;
        aligned_frame_pulse_o <= framer_frame_pulse_i;
        out_spe_o <= 1'b0;
        path_start_marker_o <= 1'b0;
        out_parity_o <= 1'b0;
      end else if (pm_byp | mode_8b) begin
        out_data_o <= fifo_data_i;
        aligned_frame_pulse_o <= fifo_frame_pulse_i;
        out_spe_o <= 1'b0;
        path_start_marker_o <= 1'b0;
        out_parity_o <= 1'b0;
      end else begin
        aligned_frame_pulse_o <= 1'b0;
        out_spe_o <= ~toh;
        path_start_marker_o <= es_path_start_marker_i & ~ais_fill_reg;
        if (ais_fill_reg & (~toh | h_time)) begin
          out_data_o <= `ALL_ONES;
          out_parity_o <= 1'b0;
        end else if (h_time & (col_reg == `COL_H1)) begin
          out_data_o <= {(ndf_reg ? `NDF_ON : `NDF_OFF), 2'b00, out_ptr[9:8]};
          out_parity_o <= ^{(ndf_reg ? `NDF_ON : `NDF_OFF), out_ptr[9:8]};
        end else if (h_time & (col_reg == `COL_H2)) begin
          out_data_o <= out_ptr[7:0];
          out_parity_o <= ^out_ptr[7:0];
        end else begin
          out_data_o <= es_data_i;
          out_parity_o <= ^es_data_i;
        end
      end
    end
  end

  // powerdown, redundancy and link selection
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_reg <= 2'b00;
      pin_sync_reg <= 2'b00;
      powerdown_o <= 8'hff;
      serial_interface_macro_pd_o <= 8'hff;
      par_protect_o <= 2'b00;
      ser_protect_o <= 2'b00;
      macro_protect_o <= 1'b0;
      link_rx_sel_o <= 8'h00;
    end else begin
      pin_meta_reg <= protect_switch_pin_i;
      pin_sync_reg <= pin_meta_reg;
      powerdown_o <= ~chan_en_reg;
      serial_interface_macro_pd_o <= ~chan_en_reg;
      // bit0 steers A/B into port A, bit1 C/D into port C
      par_protect_o <= {2{prot_ok & (ctrl_reg[`CTRL_STS12] | ctrl_reg[`CTRL_STS48])}} &
        (prot_reg[1:0] | pin_sync_reg);
      ser_protect_o <= {2{prot_ok & (ctrl_reg[`CTRL_STS12] | ctrl_reg[`CTRL_STS48])}} &
        prot_reg[3:2];
      macro_protect_o <= prot_ok & ctrl_reg[`CTRL_STS48] & ctrl_reg[`CTRL_BY_MACRO] & prot_reg[4];
      link_rx_sel_o <= ctrl_reg[`CTRL_LINK_SW] ? link_sw_reg : link_protect_select_i;
    end
  end
endmodule // sts_receive_pointer_mover

//--- sts_receive_pointer_mover_props.sv
// Purpose: port-level checks of bus, powerdown, protect and alarm fill
// Assumes: one clock, synchronous active-high reset
// Notes: a pointer pair is two strobes in back-to-back cycles
`timescale 1ns/100ps
module ptr_mover_checker (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire [31:0] dat_o,
  input wire ptr_strobe_i,
  input wire [1:0] ptr_kind_i,
  input wire [7:0] out_data_o,
  input wire new_data_flag_o,
  input wire [7:0] powerdown_o,
  input wire [7:0] serial_interface_macro_pd_o,
  input wire [1:0] ser_protect_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence pair_ais;
    ptr_strobe_i && ptr_kind_i == 2'h2 ##1 ptr_strobe_i && ptr_kind_i == 2'h2;
  endsequence
  sequence pair_normal_pointer_state;
    ptr_strobe_i && ptr_kind_i == 2'h0 ##1 ptr_strobe_i && ptr_kind_i == 2'h0;
  endsequence
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  read_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  reset_pd_a: assert property ($past(rst_i) |-> powerdown_o == 8'hff)
    else $error("channels not powered down after reset");
  macro_pd_a: assert property (serial_interface_macro_pd_o == powerdown_o)
    else $error("serial macro powerdown differs from channel");
  ser_pin_a: assert property ($changed(ser_protect_o) |-> $past(ack_o) || $past(ack_o, 2))
    else $error("serial protect moved without a write");
  ais_fill_a: assert property (pair_ais |-> ##[1:5] out_data_o == 8'hff)
    else $error("no all-ones fill in alarm");
  ais_exit_a: assert property (pair_ais ##1 pair_normal_pointer_state |-> ##[1:4] new_data_flag_o)
    else $error("no new data flag on alarm exit");
endmodule // ptr_mover_checker
bind sts_receive_pointer_mover ptr_mover_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o), .ptr_strobe_i(ptr_strobe_i), .ptr_kind_i(ptr_kind_i),
  .out_data_o(out_data_o), .new_data_flag_o(new_data_flag_o), .powerdown_o(powerdown_o),
  .serial_interface_macro_pd_o(serial_interface_macro_pd_o), .ser_protect_o(ser_protect_o));

//--- fabric_partner.sv
// Purpose: fabric side pacing system frames and choosing links
// Assumes: one system frame of 810 clocks
// Notes: link select held steady so the chosen buffer is observable
`timescale 1ns/100ps
module fabric_partner #(
  parameter FRAME = 810,
  parameter [7:0] SEL = 8'ha5
) (
  input wire clk_i,
  input wire rst_i,
  output logic line_frame_pulse_o = 1'b0,
  output logic [7:0] link_protect_select_o = 8'h00
);
  int cnt;
  always @(posedge clk_i) begin
    if (rst_i || cnt == FRAME - 1) cnt <= 0;
    else cnt <= cnt + 1;
    line_frame_pulse_o <= !rst_i && cnt == FRAME - 1;
    link_protect_select_o <= SEL;
  end
endmodule // fabric_partner

//--- tb_sts_receive_pointer_mover.sv
// Purpose: self-checking bench for the receive pointer mover
// Assumes: 50 MHz clock, classic single-cycle bus master
// Notes: table rows first, awkward cases after
`timescale 1ns/100ps
module tb_sts_receive_pointer_mover;
  logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, ptr_strobe_i, ptr_inc_i, ptr_dec_i, rx_h_time_i;
  logic line_frame_pulse_i, es_path_start_marker_i, fifo_frame_pulse_i, fifo_comma_i, framer_frame_pulse_i;
  logic decoder_comma_i, out_spe_o, path_start_marker_o, out_parity_o, aligned_frame_pulse_o;
  logic comma_detect_flag_o, recovered_timing_o, new_data_flag_o, ptr_inc_o, ptr_dec_o, macro_protect_o;
  logic [31:0] dat_i, dat_o, rd;
  logic [9:0] ptr_value_i;
  logic [7:0] es_data_i, fifo_data_i, framer_data_i, link_protect_select_i, out_data_o, powerdown_o;
  logic [7:0] serial_interface_macro_pd_o, link_rx_sel_o;
  logic [4:0] adr_i;
  logic [3:0] sel_i;
  logic [1:0] ptr_kind_i, protect_switch_pin_i, par_protect_o, ser_protect_o;
  int n_fail, check_count, i, j;
  logic [72:0] reg_rows [7] = '{{5'h04, 4'hf, 32'hffffff0f, 32'h0000000f},
    {5'h04, 4'he, 32'h000000ff, 32'h0000000f}, {5'h08, 4'hf, 32'hffffffe3, 32'h00000003},
    {5'h0c, 4'hf, 32'h0000005a, 32'h0000005a}, {5'h10, 4'hf, 32'hffffffff, 32'h0},
    {5'h14, 4'hf, 32'hffffffff, 32'h0}, {5'h00, 4'hf, 32'hffffff80, 32'h0}};
  logic [17:0] mode_rows [4] = '{{8'h01, 8'h3c, 2'b00}, {8'h03, 8'hc3, 2'b10},
    {8'h06, 8'h3c, 2'b11}, {8'h04, 8'h3c, 2'b00}};
  logic [82:0] ptr_rows [8] = '{{3'd2, 8'h00, 20'h0, 10'd10, 10'd10, 16'hffc3, 16'h0280},
    {3'd2, 8'h00, 20'h0, 10'd25, 10'd15, 16'hffc3, 16'h0640},
    {3'd3, 8'h0c, 10'd0, 10'd40, 10'd40, 10'd40, 16'hffc3, 16'h0640},
    {3'd2, 8'h05, 40'h0, 16'h0003, 16'h0002}, {3'd2, 8'h0a, 40'h0, 16'h0007, 16'h0005},
    {3'd4, 8'h0a, 10'd30, 10'd30, 20'h0, 16'hffc3, 16'h0780},
    {3'd2, 8'h00, 20'h0, 10'd900, 10'd900, 16'hffc3, 16'h0780},
    {3'd2, 8'h00, 20'h0, 10'd782, 10'd782, 16'hffc3, 16'hc380}};

  sts_receive_pointer_mover u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .ptr_strobe_i(ptr_strobe_i),
    .ptr_kind_i(ptr_kind_i), .ptr_value_i(ptr_value_i), .ptr_inc_i(ptr_inc_i), .ptr_dec_i(ptr_dec_i),
    .rx_h_time_i(rx_h_time_i), .line_frame_pulse_i(line_frame_pulse_i), .es_data_i(es_data_i),
    .es_path_start_marker_i(es_path_start_marker_i), .fifo_data_i(fifo_data_i),
    .fifo_frame_pulse_i(fifo_frame_pulse_i), .fifo_comma_i(fifo_comma_i), .framer_data_i(framer_data_i),
    .framer_frame_pulse_i(framer_frame_pulse_i), .decoder_comma_i(decoder_comma_i),
    .protect_switch_pin_i(protect_switch_pin_i), .link_protect_select_i(link_protect_select_i),
    .out_data_o(out_data_o), .out_spe_o(out_spe_o), .path_start_marker_o(path_start_marker_o),
    .out_parity_o(out_parity_o), .aligned_frame_pulse_o(aligned_frame_pulse_o),
    .comma_detect_flag_o(comma_detect_flag_o), .recovered_timing_o(recovered_timing_o),
    .new_data_flag_o(new_data_flag_o), .ptr_inc_o(ptr_inc_o), .ptr_dec_o(ptr_dec_o), .powerdown_o(powerdown_o),
    .serial_interface_macro_pd_o(serial_interface_macro_pd_o), .par_protect_o(par_protect_o),
    .ser_protect_o(ser_protect_o), .macro_protect_o(macro_protect_o), .link_rx_sel_o(link_rx_sel_o));
  fabric_partner u_fab (.clk_i(clk_i), .rst_i(rst_i), .line_frame_pulse_o(line_frame_pulse_i),
    .link_protect_select_o(link_protect_select_i));

  task give_verdict;
    begin
      if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      check_count++;
      if (g !== e) begin
        n_fail++;
        $display("ERROR %0t got %h want %h", $time, g, e);
      end
    end
  endtask

  task wb(input logic w, input logic [4:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    begin
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      do begin
        @(posedge clk_i);
        n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) chk(32'h0, 32'h1);
      if (ack_o !== 1'b1) give_verdict;
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  task ptr(input logic [1:0] k, input logic [9:0] v);
    begin
      ptr_strobe_i <= 1'b1;
      ptr_kind_i <= k;
      ptr_value_i <= v;
      @(posedge clk_i);
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    es_data_i <= rst_i ? 8'h00 : es_data_i + 8'h01;
    fifo_frame_pulse_i <= line_frame_pulse_i;
    framer_frame_pulse_i <= line_frame_pulse_i;
  end

  initial begin
    rst_i = 1'b1;
    {we_i, cyc_i, stb_i, ptr_strobe_i, ptr_inc_i, ptr_dec_i, rx_h_time_i} = 7'h0;
    {es_path_start_marker_i, fifo_comma_i} = 2'h0;
    {dat_i, ptr_value_i, ptr_kind_i, protect_switch_pin_i, adr_i, sel_i} = 55'h0;
    decoder_comma_i = 1'b1;
    fifo_data_i = 8'h3c;
    framer_data_i = 8'hc3;
    n_fail = 0;
    check_count = 0;
    repeat (12) @(posedge clk_i);
    chk({15'h0, powerdown_o, serial_interface_macro_pd_o, ack_o}, 32'h0001fffe);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 7; i++) begin
      wb(1'b1, reg_rows[i][72:68], reg_rows[i][67:64], reg_rows[i][63:32]);
      wb(1'b0, reg_rows[i][72:68], 4'hf, 32'h0);
      chk(rd, reg_rows[i][31:0]);
    end
    chk({24'h0, powerdown_o}, 32'h000000f0);
    for (i = 0; i < 4; i++) begin
      wb(1'b1, 5'h00, 4'hf, {24'h0, mode_rows[i][17:10]});
      repeat (3) @(posedge clk_i);
      chk({23'h0, out_data_o, recovered_timing_o}, {23'h0, mode_rows[i][9:1]});
      if (i < 2) chk({29'h0, out_spe_o, path_start_marker_o, out_parity_o}, 32'h0);
      else chk({31'h0, comma_detect_flag_o}, {31'h0, mode_rows[i][0]});
    end
    chk({24'h0, link_rx_sel_o}, 32'h000000a5);
    wb(1'b1, 5'h00, 4'hf, 32'h00000048);
    repeat (2) @(posedge clk_i);
    chk({24'h0, link_rx_sel_o}, 32'h0000005a);
    protect_switch_pin_i <= 2'b11;
    wb(1'b1, 5'h08, 4'hf, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({28'h0, par_protect_o, ser_protect_o}, 32'h0000000c);
    protect_switch_pin_i <= 2'b00;
    wb(1'b1, 5'h08, 4'hf, 32'h0000000c);
    repeat (3) @(posedge clk_i);
    chk({28'h0, par_protect_o, ser_protect_o}, 32'h00000003);
    wb(1'b1, 5'h00, 4'hf, 32'h0);
    for (i = 0; i < 8; i++) begin
      for (j = 0; j < ptr_rows[i][82:80]; j++) ptr(ptr_rows[i][72 + 2 * j +: 2], ptr_rows[i][32 + 10 * j +: 10]);
      ptr_strobe_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, 5'h10, 4'hf, 32'h0);
      chk(rd & {16'hffff, ptr_rows[i][31:16]}, {16'h0, ptr_rows[i][15:0]});
    end
    // increment at offset 782 wraps to 0 and is latched for the frame
    ptr_inc_i <= 1'b1;
    ptr(2'h0, 10'd782);
    ptr_inc_i <= 1'b0;
    ptr_strobe_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 5'h10, 4'hf, 32'h0);
    chk(rd & 32'h0000ffc0, 32'h0);
    j = 0;
    while (ptr_inc_o !== 1'b1 && j < 1000) begin
      @(posedge clk_i);
      j++;
    end
    chk({31'h0, ptr_inc_o}, 32'h1);
    if (ptr_inc_o !== 1'b1) give_verdict;
    // start marker ends the fill and raises new data
    es_path_start_marker_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    es_path_start_marker_i <= 1'b0;
    j = 0;
    while (new_data_flag_o !== 1'b1 && j < 8) begin
      @(posedge clk_i);
      j++;
    end
    chk({31'h0, new_data_flag_o}, 32'h1);
    if (new_data_flag_o !== 1'b1) give_verdict;
    wb(1'b0, 5'h10, 4'hf, 32'h0);
    chk(rd & 32'h00000004, 32'h0);
    wb(1'b1, 5'h00, 4'hf, 32'h00000030);
    wb(1'b1, 5'h08, 4'hf, 32'h00000010);
    repeat (2) @(posedge clk_i);
    chk({31'h0, macro_protect_o}, 32'h1);
    wb(1'b1, 5'h00, 4'hf, 32'h00000034);
    repeat (2) @(posedge clk_i);
    chk({31'h0, macro_protect_o}, 32'h0);
    wb(1'b1, 5'h00, 4'hf, 32'h00000001);
    j = 0;
    while (aligned_frame_pulse_o !== 1'b1 && j < 1000) begin
      @(posedge clk_i);
      j++;
    end
    chk({31'h0, aligned_frame_pulse_o}, 32'h1);
    if (aligned_frame_pulse_o !== 1'b1) give_verdict;
    rx_h_time_i <= 1'b1;
    @(posedge clk_i);
    rx_h_time_i <= 1'b0;
    wb(1'b0, 5'h10, 4'hf, 32'h0);
    chk(rd & 32'h00000010, 32'h00000010);
    give_verdict;
  end
endmodule // tb_sts_receive_pointer_mover
